/* core/twr_pkg.sv */
// Constants for the three-wire register port.
// Assumes a 48-bit frame: 12 address, 1 direction, 3 turnaround, 32 data.
package twr_pkg;
    localparam int ADDR_BITS     = 12;
    localparam int REG_ADDR_BITS = 4;
    localparam int DIR_BIT_POS   = 12;
    localparam int TA_BITS       = 3;
    localparam int DATA_BITS     = 32;
    localparam int FRAME_BITS    = 48;
    localparam int NUM_REGS      = 16;
    localparam logic [5:0] CNT_DIR_DONE = 6'h0D;
    localparam logic [5:0] CNT_TA_DONE  = 6'h10;
    localparam logic [5:0] CNT_LAST     = 6'h2F;
    localparam logic [1:0] KEEP_UP   = 2'h0;
    localparam logic [1:0] KEEP_DOWN = 2'h1;
    localparam logic [1:0] KEEP_HOLD = 2'h2;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage : twr_pkg

/* core/twr_port.sv */
// Three-wire serial register slave, link side on the serial clock.
// Assumes the host keeps the serial clock low when idle and frames with select_low.
`timescale 1ns/1ps
`default_nettype none
module twr_port
    import twr_pkg::*;
#(
    parameter int REG_WIDTH = twr_pkg::DATA_BITS
) (
    // System side
    input  wire logic                         MCLK,
    input  wire logic                         RESETN,
    // Serial link
    input  wire logic                         SERIAL_CLK,
    input  wire logic                         SELECT_LOW,
    input  wire logic                         BIDIR_SERIAL_LINE_IN,
    output logic                              BIDIR_SERIAL_LINE_OUT,
    output logic                              BIDIR_SERIAL_LINE_OE,
    // Keeper control and pad controls
    input  wire logic [1:0]                   KEEPER_MODE,
    output logic                              KEEPER_PULL_UP,
    output logic                              KEEPER_PULL_DOWN,
    output logic                              KEEPER_HOLD,
    // Register contents toward the receiver core
    output logic [twr_pkg::NUM_REGS*32-1:0]   REG_CONTENTS,
    output logic                              REG_WRITE_PULSE,
    output logic [3:0]                        REG_WRITE_ADDR
);
    import twr_pkg::*;

    // Elaboration check: the frame carries exactly one register width
    generate
        if (REG_WIDTH != DATA_BITS) begin : g_bad_width
            $error("twr_port: REG_WIDTH must equal the data phase length");
        end
    endgenerate

    // Frame phases, one per field of the frame, plus a final done phase
    typedef enum logic [2:0] {
        PH_ADDR,
        PH_DIR,
        PH_TURN,
        PH_DATA,
        PH_DONE
    } twr_phase_t;

    // Link domain state, cleared by select high only
    logic [5:0]           bit_cnt;
    twr_phase_t           phase;
    twr_phase_t           next_phase;
    logic [3:0]           reg_addr;
    logic                 is_read;
    logic [31:0]          shift_in;
    logic [31:0]          shift_out;
    logic                 drive;

    // Handover words from link to system domain
    logic [31:0]          wr_data;
    logic [3:0]           wr_addr;
    logic                 wr_toggle;

    // Phase decode
    logic                 in_addr;
    logic                 at_dir;
    logic                 in_data;
    logic                 frame_full;
    logic                 at_last;
    logic                 write_done;
    logic                 read_start;

    // Register store, one entry per address
    logic [31:0]          regs [NUM_REGS];
    logic [31:0]          rd_word;

    // System domain handover
    logic [2:0]           tog_sync;
    logic                 tog_seen;
    logic                 tog_stable;
    logic                 wr_event;
    logic                 released;

    // Bit counter: after rising edge k, k bits are taken
    always_ff @(posedge SERIAL_CLK or posedge SELECT_LOW) begin
        if (SELECT_LOW) begin
            bit_cnt <= 6'h00;
        end else if (!frame_full) begin
            bit_cnt <= bit_cnt + 6'h01;
        end
    end

    // Phase register, restarted by every select high
    always_ff @(posedge SERIAL_CLK or posedge SELECT_LOW) begin
        if (SELECT_LOW) begin
            phase <= PH_ADDR;
        end else begin
            phase <= next_phase;
        end
    end

    // Clocks beyond the last bit leave the frame parked in PH_DONE
    always_comb begin
        next_phase = phase;
        unique case (phase)
            PH_ADDR: begin
                if (bit_cnt == 6'(ADDR_BITS - 1)) begin
                    next_phase = PH_DIR;
                end
            end
            PH_DIR: begin
                next_phase = PH_TURN;
            end
            PH_TURN: begin
                if (bit_cnt == CNT_TA_DONE - 6'h01) begin
                    next_phase = PH_DATA;
                end
            end
            PH_DATA: begin
                if (bit_cnt == CNT_LAST) begin
                    next_phase = PH_DONE;
                end
            end
            PH_DONE: begin
                next_phase = PH_DONE;
            end
            default: begin
                next_phase = PH_ADDR;
            end
        endcase
    end

    assign in_addr    = phase == PH_ADDR;
    assign at_dir     = phase == PH_DIR;
    assign in_data    = phase == PH_DATA;
    assign frame_full = phase == PH_DONE;
    assign at_last    = in_data && (bit_cnt == CNT_LAST);
    assign write_done = at_last && !is_read;
    assign read_start = in_data && is_read && (bit_cnt == CNT_TA_DONE);

    // Only the last four address bits stay; the leading zeros shift out
    always_ff @(posedge SERIAL_CLK or posedge SELECT_LOW) begin
        if (SELECT_LOW) begin
            reg_addr <= 4'h0;
        end else if (in_addr) begin
            reg_addr <= {reg_addr[2:0], BIDIR_SERIAL_LINE_IN};
        end
    end

    // Direction bit
    always_ff @(posedge SERIAL_CLK or posedge SELECT_LOW) begin
        if (SELECT_LOW) begin
            is_read <= 1'b0;
        end else if (at_dir) begin
            is_read <= BIDIR_SERIAL_LINE_IN;
        end
    end

    // Data phase capture; turnaround bits are never shifted in
    always_ff @(posedge SERIAL_CLK or posedge SELECT_LOW) begin
        if (SELECT_LOW) begin
            shift_in <= 32'h0000_0000;
        end else if (in_data) begin
            shift_in <= {shift_in[30:0], BIDIR_SERIAL_LINE_IN};
        end
    end

    // Write word, held until the next completed write
    always_ff @(posedge SERIAL_CLK) begin
        if (write_done) begin
            wr_data <= {shift_in[30:0], BIDIR_SERIAL_LINE_IN};
        end
    end

    // Write address, held alongside the word
    always_ff @(posedge SERIAL_CLK) begin
        if (write_done) begin
            wr_addr <= reg_addr;
        end
    end

    // Toggle flips once per completed write; a cut frame never gets here
    always_ff @(posedge SERIAL_CLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_toggle <= 1'b0;
        end else if (write_done) begin
            wr_toggle <= ~wr_toggle;
        end
    end

    // Read word; the store is quiet during a read, so no resync is needed
    always_comb begin
        rd_word = regs[reg_addr];
    end

    // Falling edge launch of read data, MSB first
    always_ff @(negedge SERIAL_CLK or posedge SELECT_LOW) begin
        if (SELECT_LOW) begin
            shift_out <= 32'h0000_0000;
        end else if (read_start) begin
            shift_out <= rd_word;
        end else if (drive) begin
            shift_out <= {shift_out[30:0], 1'b0};
        end
    end

    // Drive window: end of turnaround to the falling edge after the last bit
    always_ff @(negedge SERIAL_CLK or posedge SELECT_LOW) begin
        if (SELECT_LOW) begin
            drive <= 1'b0;
        end else if (read_start) begin
            drive <= 1'b1;
        end else if (frame_full) begin
            drive <= 1'b0;
        end
    end

    // Pad controls; select high drops the enable at once, not at an edge
    assign BIDIR_SERIAL_LINE_OUT = shift_out[31] & drive;
    assign BIDIR_SERIAL_LINE_OE  = drive & ~SELECT_LOW;

    // Keeper enables only while released; mode 3 leaves the line floating
    assign released         = !BIDIR_SERIAL_LINE_OE;
    assign KEEPER_PULL_UP   = released && (KEEPER_MODE == KEEP_UP);
    assign KEEPER_PULL_DOWN = released && (KEEPER_MODE == KEEP_DOWN);
    assign KEEPER_HOLD      = released && (KEEPER_MODE == KEEP_HOLD);

    // Toggle through three stages; a change counts once the last two agree
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            tog_sync <= 3'h0;
        end else begin
            tog_sync <= {tog_sync[1:0], wr_toggle};
        end
    end

    assign tog_stable = tog_sync[1] == tog_sync[2];
    assign wr_event   = tog_stable && (tog_sync[2] != tog_seen);

    // Last toggle level acted on
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            tog_seen <= 1'b0;
        end else if (tog_stable) begin
            tog_seen <= tog_sync[2];
        end
    end

    // Register store; word and address are stable long before the toggle lands
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            always_ff @(posedge MCLK or negedge RESETN) begin
                if (!RESETN) begin
                    regs[g] <= REG_RESET;
                end else if (wr_event && (wr_addr == 4'(g))) begin
                    regs[g] <= wr_data;
                end
            end
            assign REG_CONTENTS[g*32 +: 32] = regs[g];
        end
    endgenerate

    // One system clock pulse per landed write
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            REG_WRITE_PULSE <= 1'b0;
        end else begin
            REG_WRITE_PULSE <= wr_event;
        end
    end

    // Address of the last landed write
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            REG_WRITE_ADDR <= 4'h0;
        end else if (wr_event) begin
            REG_WRITE_ADDR <= wr_addr;
        end
    end
endmodule : twr_port
`default_nettype wire

/* verif/twr_host.sv */
// Host model: serial clock, select and the host half of the line.
// Assumes the bench resolves the shared line and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module twr_host (
    // Link toward the port
    output logic      SERIAL_CLK,
    output logic      SELECT_LOW,
    output logic      HOST_OUT,
    output logic      HOST_OE,
    // Resolved line level
    input  wire logic BIDIR_SERIAL_LINE_IN
);
    // Select rises after time zero so the port sees a clean clearing edge
    initial begin
        {SERIAL_CLK, SELECT_LOW, HOST_OUT, HOST_OE} = 4'h0;
        #1 SELECT_LOW = 1'b1;
    end
    // Clock stands low outside frames; n below 48 cuts a frame short
    task automatic frame(input logic sel, rd, input logic [3:0] a, input logic [31:0] d,
                         input int n, output logic [31:0] q);
        logic [47:0] f;
        f = {8'h00, a, rd, 3'h0, d};
        SELECT_LOW = sel;
        #23;
        for (int i = 0; i < n; i++) begin
            HOST_OUT = f[47 - i];
            HOST_OE = !rd || i < 13;
            #15 SERIAL_CLK = 1'b1;
            q = {q[30:0], BIDIR_SERIAL_LINE_IN};
            #15 SERIAL_CLK = 1'b0;
        end
        HOST_OE = 1'b0;
        #20 SELECT_LOW = 1'b1;
        #100;
    endtask : frame
endmodule : twr_host
`default_nettype wire

/* verif/twr_port_checker.sv */
// Assertions on the ports of the three-wire register port.
// Assumes BIDIR_SERIAL_LINE_IN carries the resolved line level.
`timescale 1ns/1ps
`default_nettype none
module twr_port_checker (
    // Clocks and reset
    input wire logic                            MCLK,
    input wire logic                            RESETN,
    // Link
    input wire logic                            SERIAL_CLK,
    input wire logic                            SELECT_LOW,
    input wire logic                            BIDIR_SERIAL_LINE_IN,
    input wire logic                            BIDIR_SERIAL_LINE_OUT,
    input wire logic                            BIDIR_SERIAL_LINE_OE,
    // Keeper
    input wire logic [1:0]                      KEEPER_MODE,
    input wire logic                            KEEPER_PULL_UP,
    input wire logic                            KEEPER_PULL_DOWN,
    input wire logic                            KEEPER_HOLD,
    // Register side
    input wire logic [twr_pkg::NUM_REGS*32-1:0] REG_CONTENTS,
    input wire logic                            REG_WRITE_PULSE,
    input wire logic [3:0]                      REG_WRITE_ADDR
);
    import twr_pkg::*;
    logic [5:0]  cnt;
    logic [47:0] sh;
    logic [3:0]  ad;
    logic        rd, wdone;
    wire         oe = BIDIR_SERIAL_LINE_OE;
    wire [2:0]   kx = {KEEPER_MODE == KEEP_UP, KEEPER_MODE == KEEP_DOWN, KEEPER_MODE == KEEP_HOLD};
    // Select high is the only clear the link has
    always_ff @(posedge SERIAL_CLK or posedge SELECT_LOW)
        if (SELECT_LOW) cnt <= 6'h00;
        else if (cnt != 6'h30) cnt <= cnt + 6'h01;
    always_ff @(posedge SERIAL_CLK) begin
        sh <= {sh[46:0], BIDIR_SERIAL_LINE_IN};
        if (cnt == 6'h0C) {ad, rd} <= {sh[3:0], BIDIR_SERIAL_LINE_IN};
        wdone <= cnt == 6'h2F && !rd;
    end
    sequence s_land;
        ##[1:8] REG_WRITE_PULSE;
    endsequence
    chk_ta_quiet: assert property (@(posedge SERIAL_CLK) disable iff (SELECT_LOW) cnt < 6'h10 |-> !oe)
        else $error("line driven early");
    chk_oe_dir: assert property (@(posedge SERIAL_CLK) disable iff (SELECT_LOW) oe |-> rd)
        else $error("line driven in write");
    chk_read_data: assert property (@(posedge SERIAL_CLK) disable iff (SELECT_LOW)
        rd && cnt >= 6'h10 && cnt < 6'h30 |-> oe && BIDIR_SERIAL_LINE_OUT == REG_CONTENTS[{ad, 5'h00} + 6'h2F - cnt])
        else $error("bad read bit");
    chk_oe_release: assert property (@(posedge MCLK) disable iff (!RESETN)
        cnt == 6'h30 && !SERIAL_CLK && $past(SERIAL_CLK) == 1'b0 |-> !oe)
        else $error("line held after frame");
    chk_oe_sel: assert property (@(posedge MCLK) disable iff (!RESETN) SELECT_LOW && $past(SELECT_LOW) |-> !oe)
        else $error("line driven unselected");
    chk_write_land: assert property (@(posedge MCLK) disable iff (!RESETN) $rose(wdone) |-> s_land)
        else $error("write not landed");
    chk_write_value: assert property (@(posedge MCLK) disable iff (!RESETN) REG_WRITE_PULSE |->
        REG_WRITE_ADDR == ad && REG_CONTENTS[{REG_WRITE_ADDR, 5'h00} +: 32] == sh[31:0])
        else $error("bad write value");
    chk_pulse_cause: assert property (@(posedge MCLK) disable iff (!RESETN) REG_WRITE_PULSE |-> wdone)
        else $error("write without frame");
    chk_keeper_mode: assert property (@(posedge MCLK) disable iff (!RESETN) KEEPER_MODE == $past(KEEPER_MODE, 3)
        && oe == $past(oe, 3) |-> {KEEPER_PULL_UP, KEEPER_PULL_DOWN, KEEPER_HOLD} == (oe ? 3'h0 : kx))
        else $error("bad keeper");
endmodule : twr_port_checker
bind twr_port twr_port_checker u_twr_port_checker (
    .MCLK                  (MCLK),
    .RESETN                (RESETN),
    .SERIAL_CLK            (SERIAL_CLK),
    .SELECT_LOW            (SELECT_LOW),
    .BIDIR_SERIAL_LINE_IN  (BIDIR_SERIAL_LINE_IN),
    .BIDIR_SERIAL_LINE_OUT (BIDIR_SERIAL_LINE_OUT),
    .BIDIR_SERIAL_LINE_OE  (BIDIR_SERIAL_LINE_OE),
    .KEEPER_MODE           (KEEPER_MODE),
    .KEEPER_PULL_UP        (KEEPER_PULL_UP),
    .KEEPER_PULL_DOWN      (KEEPER_PULL_DOWN),
    .KEEPER_HOLD           (KEEPER_HOLD),
    .REG_CONTENTS          (REG_CONTENTS),
    .REG_WRITE_PULSE       (REG_WRITE_PULSE),
    .REG_WRITE_ADDR        (REG_WRITE_ADDR)
);
`default_nettype wire

/* verif/twr_port_test.sv */
// Self-checking bench: host model frames against the register port.
// Assumes a released line follows the keeper, and floats to the inverse of its last level.
`timescale 1ns/1ps
`default_nettype none
module twr_port_test;
    import twr_pkg::*;
    logic MCLK = 1'b0;
    logic RESETN = 1'b1;
    logic line_last = 1'b0;
    logic [1:0] KEEPER_MODE = KEEP_UP;
    logic seen;
    logic [31:0] q;
    int bad_count = 0;
    int cmp_count = 0;
    wire SERIAL_CLK, SELECT_LOW, HOST_OUT, HOST_OE, BIDIR_SERIAL_LINE_OUT, BIDIR_SERIAL_LINE_OE, REG_WRITE_PULSE;
    wire KEEPER_PULL_UP, KEEPER_PULL_DOWN, KEEPER_HOLD;
    wire [NUM_REGS*32-1:0] REG_CONTENTS;
    wire [3:0] REG_WRITE_ADDR;
    wire line_on  = BIDIR_SERIAL_LINE_OE | HOST_OE;
    wire line_drv = BIDIR_SERIAL_LINE_OE ? BIDIR_SERIAL_LINE_OUT : HOST_OUT;
    wire BIDIR_SERIAL_LINE_IN = line_on ? line_drv : KEEPER_PULL_UP ? 1'b1 : KEEPER_PULL_DOWN ? 1'b0 :
                                KEEPER_HOLD ? line_last : ~line_last;
    always @* if (line_on) line_last = line_drv;
    twr_port u_twr_port (
        .MCLK                  (MCLK),
        .RESETN                (RESETN),
        .SERIAL_CLK            (SERIAL_CLK),
        .SELECT_LOW            (SELECT_LOW),
        .BIDIR_SERIAL_LINE_IN  (BIDIR_SERIAL_LINE_IN),
        .BIDIR_SERIAL_LINE_OUT (BIDIR_SERIAL_LINE_OUT),
        .BIDIR_SERIAL_LINE_OE  (BIDIR_SERIAL_LINE_OE),
        .KEEPER_MODE           (KEEPER_MODE),
        .KEEPER_PULL_UP        (KEEPER_PULL_UP),
        .KEEPER_PULL_DOWN      (KEEPER_PULL_DOWN),
        .KEEPER_HOLD           (KEEPER_HOLD),
        .REG_CONTENTS          (REG_CONTENTS),
        .REG_WRITE_PULSE       (REG_WRITE_PULSE),
        .REG_WRITE_ADDR        (REG_WRITE_ADDR)
    );
    twr_host u_twr_host (
        .SERIAL_CLK            (SERIAL_CLK),
        .SELECT_LOW            (SELECT_LOW),
        .HOST_OUT              (HOST_OUT),
        .HOST_OE               (HOST_OE),
        .BIDIR_SERIAL_LINE_IN  (BIDIR_SERIAL_LINE_IN)
    );
    always #5 MCLK = ~MCLK;
    always @(posedge MCLK) if (REG_WRITE_PULSE === 1'b1) seen <= 1'b1;
    task automatic check(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic results;
        $display("%0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input int n);
        seen = 1'b0;
        u_twr_host.frame(1'b0, 1'b0, a, d, n, q);
        for (int i = 0; i < 20 && seen !== 1'b1; i++) @(negedge MCLK);
        check(seen, n == 48);
        if (n == 48 && seen !== 1'b1) results();
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        u_twr_host.frame(1'b0, 1'b1, a, 32'h0000_0000, 48, q);
        check(q, e);
    endtask : rd
    task automatic t_access;
        rd(4'h3, REG_RESET);
        wr(4'h5, 32'hA5C3_0F96, 48);
        rd(4'h5, 32'hA5C3_0F96);
        wr(4'hF, 32'h8000_0001, 48);
        rd(4'hF, 32'h8000_0001);
        $display("test access done");
    endtask : t_access
    task automatic t_refuse;
        wr(4'h5, 32'h1234_5678, 47);
        u_twr_host.frame(1'b1, 1'b0, 4'h5, 32'h0000_0000, 48, q);
        rd(4'h5, 32'hA5C3_0F96);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_keeper;
        for (int m = 0; m < 4; m++) begin
            KEEPER_MODE = m[1:0];
            repeat (4) @(negedge MCLK);
            check({KEEPER_PULL_UP, KEEPER_PULL_DOWN, KEEPER_HOLD}, {m == KEEP_UP, m == KEEP_DOWN, m == KEEP_HOLD});
        end
        rd(4'hF, 32'h8000_0001);
        $display("test keeper done");
    endtask : t_keeper
    initial begin
        #1 RESETN = 1'b0;
        repeat (10) @(negedge MCLK);
        RESETN = 1'b1;
        t_access();
        t_refuse();
        t_keeper();
        results();
    end
endmodule : twr_port_test
`default_nettype wire
